// ### src/asf_defs.svh
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH

// register indices; the byte address on the bus is four times the index
`define ASF_IDX_ARITH        8'h04
`define ASF_IDX_CPU_STATE    8'h06
`define ASF_ADDR_ARITH       (`ASF_IDX_ARITH << 2)
`define ASF_ADDR_CPU_STATE   (`ASF_IDX_CPU_STATE << 2)

// arith_flags_pointer_mode field positions
`define ASF_P1_MODE_HI       7
`define ASF_P1_MODE_LO       6
`define ASF_P0_MODE_HI       5
`define ASF_P0_MODE_LO       4
`define ASF_OVF_BIT          3
`define ASF_ZERO_BIT         2
`define ASF_NIB_BIT          1
`define ASF_CARRY_BIT        0

// cpu_state_control field positions
`define ASF_CPU_STACK_BIT    5
`define ASF_CPU_GDIS_BIT     4
`define ASF_CPU_WDT_BIT      3
`define ASF_CPU_SLEEP_BIT    2

// reset values
`define ASF_ARITH_RST        8'hF0
`define ASF_CPU_GDIS_RST     1'b1
`define ASF_BYTE_ZERO        8'h00
`define ASF_READ_PAD         24'h00_0000

// pointer mode codes; any code with the upper bit set holds the pointer
`define ASF_MODE_DEC         2'b00
`define ASF_MODE_INC         2'b01
`define ASF_PTR_STEP         8'h01

// width of the low-order digit whose carry feeds the nibble flag
`define ASF_NIB_W            4

`endif

// ### src/asf_pkg.sv
package asf_pkg;

  typedef enum logic [3:0] {
    ASF_OP_NONE,
    ASF_OP_ADD,
    ASF_OP_SUB,
    ASF_OP_INC,
    ASF_OP_DEC,
    ASF_OP_AND,
    ASF_OP_IOR,
    ASF_OP_XOR,
    ASF_OP_CLR,
    ASF_OP_MOV,
    ASF_OP_RRC,
    ASF_OP_RLC
  } asf_op_type;

  typedef struct packed {
    asf_op_type   op;
    logic [7:0]   a;
    logic [7:0]   b;
  } asf_alu_req_type;

  typedef struct packed {
    logic         ovf;
    logic         zero;
    logic         nib;
    logic         carry;
  } asf_flags_type;

  typedef enum logic {
    ASF_BUS_IDLE,
    ASF_BUS_ACK
  } asf_bus_state_type;

endpackage

// ### src/asf_addsub.sv
`timescale 1ns/10ps
`include "asf_defs.svh"

// add or subtract; subtraction adds the two's complement of b, so both
// carries read as "no borrow" when set
module asf_addsub #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] a,
  input  wire logic [WIDTH-1:0] b,
  input  wire logic             sub,
  output logic      [WIDTH-1:0] sum,
  output logic                  nib_carry,
  output logic                  carry,
  output logic                  ovf
);

  logic [WIDTH-1:0]      b_eff;
  logic [WIDTH:0]        full;
  logic [`ASF_NIB_W:0]   low;

  // refused at elaboration: the digit carry needs bits above the digit
  if (WIDTH <= `ASF_NIB_W) begin
    $error("asf_addsub: WIDTH must exceed the digit width");
  end

  always_comb begin
    b_eff     = sub ? ~b : b;
    full      = {1'b0, a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, sub};
    low       = {1'b0, a[`ASF_NIB_W-1:0]} + {1'b0, b_eff[`ASF_NIB_W-1:0]}
              + {{`ASF_NIB_W{1'b0}}, sub};
    sum       = full[WIDTH-1:0];
    carry     = full[WIDTH];
    nib_carry = low[`ASF_NIB_W];
    // sign flips although both operands carried the same sign
    ovf       = (a[WIDTH-1] == b_eff[WIDTH-1])
              && (full[WIDTH-1] != a[WIDTH-1]);
  end

endmodule

// ### src/asf_status_top.sv
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
`include "asf_defs.svh"

// Overview of operation
// - pointer one mode: 00 dec, 01 inc, 1x hold
// - pointer zero mode: 00 dec, 01 inc, 1x hold
// - overflow flag set on signed sign-bit overflow
// - zero flag follows zero result of arithmetic and logic ops, not mov or rotates
// - nibble flag is carry out of bit three
// - carry flag is carry out of msb
// - subtraction flags set means no borrow
// - subtract by adding two's complement operand
// - rotates load carry with shifted-out bit
// - cpu status holds global interrupt disable
// - hardware-owned status bits ignore software writes
// - stored status may differ from written value
// - pointer stepping never touches arithmetic flags
module asf_status_top #(
  parameter int DATA_W = 8,
  parameter int BUS_W  = 32
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic [7:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [BUS_W-1:0]           avs_writedata,
  input  wire logic [BUS_W/8-1:0]         avs_byteenable,
  output logic      [BUS_W-1:0]           avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic                       alu_req_valid,
  input  wire asf_pkg::asf_alu_req_type   alu_req,
  output logic      [DATA_W-1:0]          alu_result,
  output logic                            alu_result_valid,
  output asf_pkg::asf_flags_type          alu_flags,
  input  wire logic                       ind_access,
  input  wire logic                       ind_ptr_sel,
  input  wire logic [DATA_W-1:0]          ind_ptr_value,
  output logic                            ptr_update_valid,
  output logic                            ptr_update_sel,
  output logic      [DATA_W-1:0]          ptr_update_value,
  input  wire logic                       watchdog_expired_n,
  input  wire logic                       sleep_entered_n,
  input  wire logic                       stack_space_flag,
  output logic                            global_irq_disable,
  output logic      [1:0]                 pointer_zero_mode_sel,
  output logic      [1:0]                 pointer_one_mode_sel
);

  if (DATA_W != 8 || BUS_W != 32) begin
    $error("asf_status_top: only 8-bit data on a 32-bit bus is served");
  end

  // bus slave: one wait state, answer on the second edge of a request
  asf_pkg::asf_bus_state_type   bus_state_q;
  asf_pkg::asf_bus_state_type   bus_state_d;
  logic                         wait_q;
  logic                         wait_d;
  logic [BUS_W-1:0]             rdata_q;
  logic [BUS_W-1:0]             rdata_d;
  logic                         wr_fire;
  logic                         wr_arith;
  logic                         wr_cpu;

  // register state
  logic [7:0]                   arith_q;
  logic [7:0]                   arith_d;
  logic                         gdis_q;
  logic                         gdis_d;
  logic                         wdt_n_q;
  logic                         sleep_n_q;
  logic                         stack_q;
  logic [7:0]                   cpu_read;

  // alu
  logic [DATA_W-1:0]            as_b;
  logic                         as_sub;
  logic [DATA_W-1:0]            as_sum;
  logic                         as_nib;
  logic                         as_carry;
  logic                         as_ovf;
  logic [DATA_W-1:0]            res;
  asf_pkg::asf_flags_type       flg_new;
  asf_pkg::asf_flags_type       flg_mask;
  logic [DATA_W-1:0]            res_q;
  logic [DATA_W-1:0]            res_d;
  logic                         res_vld_q;
  logic                         res_vld_d;

  // pointer stepping
  logic [1:0]                   ptr_mode;
  logic [DATA_W-1:0]            ptr_val_q;
  logic [DATA_W-1:0]            ptr_val_d;
  logic                         ptr_vld_q;
  logic                         ptr_vld_d;
  logic                         ptr_sel_q;
  logic                         ptr_sel_d;

  always_comb begin
    // hardware-owned bits are registered from device logic, never from writes
    cpu_read                     = `ASF_BYTE_ZERO;
    cpu_read[`ASF_CPU_STACK_BIT] = stack_q;
    cpu_read[`ASF_CPU_GDIS_BIT]  = gdis_q;
    cpu_read[`ASF_CPU_WDT_BIT]   = wdt_n_q;
    cpu_read[`ASF_CPU_SLEEP_BIT] = sleep_n_q;
  end

  always_comb begin
    bus_state_d = bus_state_q;
    wait_d      = wait_q;
    rdata_d     = rdata_q;
    unique case (bus_state_q)
      asf_pkg::ASF_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_state_d = asf_pkg::ASF_BUS_ACK;
          wait_d      = 1'b0;
          if (avs_address == `ASF_ADDR_ARITH) begin
            rdata_d = {`ASF_READ_PAD, arith_q};
          end else if (avs_address == `ASF_ADDR_CPU_STATE) begin
            rdata_d = {`ASF_READ_PAD, cpu_read};
          end else begin
            rdata_d = {`ASF_READ_PAD, `ASF_BYTE_ZERO};
          end
        end
      end
      asf_pkg::ASF_BUS_ACK: begin
        bus_state_d = asf_pkg::ASF_BUS_IDLE;
        wait_d      = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_q <= asf_pkg::ASF_BUS_IDLE;
      wait_q      <= 1'b1;
      rdata_q     <= {`ASF_READ_PAD, `ASF_BYTE_ZERO};
    end else begin
      bus_state_q <= bus_state_d;
      wait_q      <= wait_d;
      rdata_q     <= rdata_d;
    end
  end

  // a write lands at the edge where waitrequest is seen low
  assign wr_fire  = (bus_state_q == asf_pkg::ASF_BUS_ACK) && avs_write
                  && avs_byteenable[0];
  assign wr_arith = wr_fire && (avs_address == `ASF_ADDR_ARITH);
  assign wr_cpu   = wr_fire && (avs_address == `ASF_ADDR_CPU_STATE);

  // cpu status: only the interrupt disable takes write data
  always_comb begin
    gdis_d = gdis_q;
    if (wr_cpu) begin
      gdis_d = avs_writedata[`ASF_CPU_GDIS_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gdis_q    <= `ASF_CPU_GDIS_RST;
      wdt_n_q   <= 1'b1;
      sleep_n_q <= 1'b1;
      stack_q   <= 1'b1;
    end else begin
      gdis_q    <= gdis_d;
      // writes cannot reach these, so a read-back may differ from the
      // value written
      wdt_n_q   <= watchdog_expired_n;
      sleep_n_q <= sleep_entered_n;
      stack_q   <= stack_space_flag;
    end
  end

  // subtraction and decrement go through the adder as two's complement
  always_comb begin
    as_sub = 1'b0;
    as_b   = alu_req.b;
    unique case (alu_req.op)
      asf_pkg::ASF_OP_SUB: begin
        as_sub = 1'b1;
      end
      asf_pkg::ASF_OP_INC: begin
        as_b = `ASF_PTR_STEP;
      end
      asf_pkg::ASF_OP_DEC: begin
        as_sub = 1'b1;
        as_b   = `ASF_PTR_STEP;
      end
      default: begin
        as_b = alu_req.b;
      end
    endcase
  end

  asf_addsub #(
    .WIDTH     (DATA_W)
  ) u_addsub (
    .a         (alu_req.a),
    .b         (as_b),
    .sub       (as_sub),
    .sum       (as_sum),
    .nib_carry (as_nib),
    .carry     (as_carry),
    .ovf       (as_ovf)
  );

  always_comb begin
    res      = as_sum;
    flg_new  = '{ovf: as_ovf, zero: 1'b0, nib: as_nib, carry: as_carry};
    flg_mask = '{ovf: 1'b0, zero: 1'b0, nib: 1'b0, carry: 1'b0};
    unique case (alu_req.op)
      asf_pkg::ASF_OP_ADD, asf_pkg::ASF_OP_SUB,
      asf_pkg::ASF_OP_INC, asf_pkg::ASF_OP_DEC: begin
        // carries read inverted as borrow after subtraction
        flg_mask = '{ovf: 1'b1, zero: 1'b1, nib: 1'b1, carry: 1'b1};
      end
      asf_pkg::ASF_OP_AND: begin
        res           = alu_req.a & alu_req.b;
        flg_mask.zero = 1'b1;
      end
      asf_pkg::ASF_OP_IOR: begin
        res           = alu_req.a | alu_req.b;
        flg_mask.zero = 1'b1;
      end
      asf_pkg::ASF_OP_XOR: begin
        res           = alu_req.a ^ alu_req.b;
        flg_mask.zero = 1'b1;
      end
      asf_pkg::ASF_OP_CLR: begin
        res           = {DATA_W{1'b0}};
        flg_mask.zero = 1'b1;
      end
      asf_pkg::ASF_OP_MOV: begin
        res = alu_req.a;
      end
      asf_pkg::ASF_OP_RRC: begin
        res            = {arith_q[`ASF_CARRY_BIT], alu_req.a[DATA_W-1:1]};
        flg_new.carry  = alu_req.a[0];
        flg_mask.carry = 1'b1;
      end
      asf_pkg::ASF_OP_RLC: begin
        res            = {alu_req.a[DATA_W-2:0], arith_q[`ASF_CARRY_BIT]};
        flg_new.carry  = alu_req.a[DATA_W-1];
        flg_mask.carry = 1'b1;
      end
      default: begin
        res = alu_req.a;
      end
    endcase
    flg_new.zero = (res == {DATA_W{1'b0}});
  end

  always_comb begin
    arith_d   = arith_q;
    res_d     = res_q;
    res_vld_d = alu_req_valid;
    if (wr_arith) begin
      arith_d = avs_writedata[7:0];
    end
    // the operation overrides a same-cycle software write of the flags it updates
    if (alu_req_valid) begin
      res_d = res;
      if (flg_mask.ovf) begin
        arith_d[`ASF_OVF_BIT] = flg_new.ovf;
      end
      if (flg_mask.zero) begin
        arith_d[`ASF_ZERO_BIT] = flg_new.zero;
      end
      if (flg_mask.nib) begin
        arith_d[`ASF_NIB_BIT] = flg_new.nib;
      end
      if (flg_mask.carry) begin
        arith_d[`ASF_CARRY_BIT] = flg_new.carry;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arith_q   <= `ASF_ARITH_RST;
      res_q     <= {DATA_W{1'b0}};
      res_vld_q <= 1'b0;
    end else begin
      arith_q   <= arith_d;
      res_q     <= res_d;
      res_vld_q <= res_vld_d;
    end
  end

  // pointer step; this path has no route into the flag register
  always_comb begin
    ptr_mode  = ind_ptr_sel
              ? arith_q[`ASF_P1_MODE_HI:`ASF_P1_MODE_LO]
              : arith_q[`ASF_P0_MODE_HI:`ASF_P0_MODE_LO];
    ptr_vld_d = ind_access;
    ptr_sel_d = ptr_sel_q;
    ptr_val_d = ptr_val_q;
    if (ind_access) begin
      ptr_sel_d = ind_ptr_sel;
      if (ptr_mode == `ASF_MODE_DEC) begin
        ptr_val_d = ind_ptr_value - `ASF_PTR_STEP;
      end else if (ptr_mode == `ASF_MODE_INC) begin
        ptr_val_d = ind_ptr_value + `ASF_PTR_STEP;
      end else begin
        ptr_val_d = ind_ptr_value;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_val_q <= {DATA_W{1'b0}};
      ptr_vld_q <= 1'b0;
      ptr_sel_q <= 1'b0;
    end else begin
      ptr_val_q <= ptr_val_d;
      ptr_vld_q <= ptr_vld_d;
      ptr_sel_q <= ptr_sel_d;
    end
  end

  assign avs_readdata          = rdata_q;
  assign avs_waitrequest       = wait_q;
  assign alu_result            = res_q;
  assign alu_result_valid      = res_vld_q;
  assign alu_flags.ovf         = arith_q[`ASF_OVF_BIT];
  assign alu_flags.zero        = arith_q[`ASF_ZERO_BIT];
  assign alu_flags.nib         = arith_q[`ASF_NIB_BIT];
  assign alu_flags.carry       = arith_q[`ASF_CARRY_BIT];
  assign ptr_update_valid      = ptr_vld_q;
  assign ptr_update_sel        = ptr_sel_q;
  assign ptr_update_value      = ptr_val_q;
  assign global_irq_disable    = gdis_q;
  assign pointer_zero_mode_sel = arith_q[`ASF_P0_MODE_HI:`ASF_P0_MODE_LO];
  assign pointer_one_mode_sel  = arith_q[`ASF_P1_MODE_HI:`ASF_P1_MODE_LO];

endmodule

// ### testbench/asf_status_asserts.sv
`timescale 1ns/10ps
module asf_status_asserts #(
  parameter int DATA_W = 8,
  parameter int BUS_W  = 32
) (
  input wire logic                     mclk,
  input wire logic                     rst_n,
  input wire logic                     avs_write,
  input wire logic                     alu_req_valid,
  input wire asf_pkg::asf_alu_req_type alu_req,
  input wire logic [DATA_W-1:0]        alu_result,
  input wire asf_pkg::asf_flags_type   alu_flags,
  input wire logic                     ind_access,
  input wire logic                     ind_ptr_sel,
  input wire logic [DATA_W-1:0]        ind_ptr_value,
  input wire logic                     ptr_update_valid,
  input wire logic [DATA_W-1:0]        ptr_update_value,
  input wire logic                     global_irq_disable,
  input wire logic [1:0]               pointer_zero_mode_sel,
  input wire logic [1:0]               pointer_one_mode_sel
);
  asf_pkg::asf_alu_req_type r_q;
  logic [7:0]               pv_q;
  logic [7:0]               pe;
  logic [1:0]               pm_q;
  logic                     sb;
  logic [7:0]               x;
  logic [8:0]               s;
  logic [4:0]               n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_q  <= '0;
      pv_q <= '0;
      pm_q <= '0;
    end else begin
      r_q  <= alu_req;
      pv_q <= ind_ptr_value[7:0];
      pm_q <= ind_ptr_sel ? pointer_one_mode_sel : pointer_zero_mode_sel;
    end
  end
  // independent adder: subtraction adds the inverted operand plus one
  always_comb begin
    sb = (r_q.op == asf_pkg::ASF_OP_SUB);
    x  = sb ? ~r_q.b : r_q.b;
    s  = {1'b0, r_q.a} + {1'b0, x} + {8'h00, sb};
    n  = {1'b0, r_q.a[3:0]} + {1'b0, x[3:0]} + {4'h0, sb};
    case (pm_q)
      2'b00:   pe = pv_q - 8'h01;
      2'b01:   pe = pv_q + 8'h01;
      default: pe = pv_q;
    endcase
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_arith;
    alu_req_valid && alu_req.op inside {asf_pkg::ASF_OP_ADD,
                                        asf_pkg::ASF_OP_SUB};
  endsequence
  sequence s_rot;
    alu_req_valid && alu_req.op inside {asf_pkg::ASF_OP_RRC,
                                        asf_pkg::ASF_OP_RLC};
  endsequence
  property p_carry;
    s_arith |=> alu_flags.carry == s[8] && alu_result[7:0] == s[7:0];
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry or sum wrong");
  property p_nib;
    s_arith |=> alu_flags.nib == n[4];
  endproperty
  a_nib: assert property (p_nib)
    else $error("nibble flag wrong");
  property p_ovf;
    s_arith |=> alu_flags.ovf == (r_q.a[7] == x[7] && s[7] != r_q.a[7]);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("signed range flag wrong");
  property p_zero;
    alu_req_valid && !(alu_req.op inside {asf_pkg::ASF_OP_NONE,
      asf_pkg::ASF_OP_MOV, asf_pkg::ASF_OP_RRC, asf_pkg::ASF_OP_RLC})
      |=> alu_flags.zero == (alu_result == '0);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");
  property p_rot;
    s_rot |=> alu_flags.carry ==
      (r_q.op == asf_pkg::ASF_OP_RRC ? r_q.a[0] : r_q.a[7]);
  endproperty
  a_rot: assert property (p_rot)
    else $error("rotate carry wrong");
  property p_keep;
    (!alu_req_valid || alu_req.op inside {asf_pkg::ASF_OP_NONE,
      asf_pkg::ASF_OP_MOV}) && !avs_write |=> $stable(alu_flags);
  endproperty
  a_keep: assert property (p_keep)
    else $error("flags changed without an op");
  property p_ptr;
    ind_access |=> ptr_update_valid && ptr_update_value[7:0] == pe;
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("pointer step wrong");
  property p_gdis;
    !avs_write |=> $stable(global_irq_disable);
  endproperty
  a_gdis: assert property (p_gdis)
    else $error("interrupt disable changed");
endmodule

bind asf_status_top asf_status_asserts #(.DATA_W(DATA_W), .BUS_W(BUS_W))
  i_chk (.mclk, .rst_n, .avs_write, .alu_req_valid, .alu_req, .alu_result,
  .alu_flags, .ind_access, .ind_ptr_sel, .ind_ptr_value, .ptr_update_valid,
  .ptr_update_value, .global_irq_disable, .pointer_zero_mode_sel,
  .pointer_one_mode_sel);

// ### testbench/asf_dp_model.sv
`timescale 1ns/10ps
// stand-in for the execution datapath; operands are scrambled when idle
module asf_dp_model (
  input  wire logic                mclk,
  output logic                     alu_req_valid,
  output asf_pkg::asf_alu_req_type alu_req,
  output logic                     ind_access,
  output logic                     ind_ptr_sel,
  output logic [7:0]               ind_ptr_value,
  output logic                     watchdog_expired_n,
  output logic                     sleep_entered_n,
  output logic                     stack_space_flag
);
  initial begin
    alu_req_valid = 1'h0;
    alu_req = '0;
    ind_access = 1'h0;
    ind_ptr_sel = 1'h0;
    ind_ptr_value = 8'h00;
    {watchdog_expired_n, sleep_entered_n, stack_space_flag} = 3'h7;
  end
  task automatic op(input asf_pkg::asf_op_type o, input logic [7:0] a, b);
    @(posedge mclk);
    alu_req_valid <= 1'h1;
    alu_req <= '{o, a, b};
    @(posedge mclk);
    alu_req_valid <= 1'h0;
    alu_req.a <= ~a;
    alu_req.b <= ~b;
    #1;
  endtask
  task automatic step(input logic sel, input logic [7:0] v);
    @(posedge mclk);
    ind_access <= 1'h1;
    ind_ptr_sel <= sel;
    ind_ptr_value <= v;
    @(posedge mclk);
    ind_access <= 1'h0;
    ind_ptr_value <= ~v;
    #1;
  endtask
  task automatic hw(input logic [2:0] v);
    @(posedge mclk);
    {watchdog_expired_n, sleep_entered_n, stack_space_flag} <= v;
  endtask
endmodule

// ### testbench/alu_status_flags_tb.sv
`timescale 1ns/10ps
`include "asf_defs.svh"
module alu_status_flags_tb;
  logic                     mclk, rst_n, avs_read, avs_write;
  logic [7:0]               avs_address, alu_result, ind_ptr_value;
  logic [7:0]               ptr_update_value, v, pe;
  logic [31:0]              avs_writedata, avs_readdata, rd;
  logic [3:0]               avs_byteenable, f_e;
  logic [1:0]               pointer_zero_mode_sel, pointer_one_mode_sel;
  logic                     avs_waitrequest, alu_req_valid, alu_result_valid;
  logic                     ind_access, ind_ptr_sel, ptr_update_valid;
  logic                     ptr_update_sel, global_irq_disable;
  logic                     watchdog_expired_n, sleep_entered_n;
  logic                     stack_space_flag;
  logic [11:0]              m;
  logic [15:0]              pr [4];
  asf_pkg::asf_alu_req_type alu_req;
  asf_pkg::asf_flags_type   alu_flags;
  asf_pkg::asf_op_type      o;
  int                       error_cnt, checked;

  always #25 mclk = ~mclk;

  asf_status_top i_dut (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .alu_req_valid, .alu_req, .alu_result, .alu_result_valid, .alu_flags,
    .ind_access, .ind_ptr_sel, .ind_ptr_value, .ptr_update_valid,
    .ptr_update_sel, .ptr_update_value, .watchdog_expired_n,
    .sleep_entered_n, .stack_space_flag, .global_irq_disable,
    .pointer_zero_mode_sel, .pointer_one_mode_sel);
  asf_dp_model i_dp (.mclk, .alu_req_valid, .alu_req, .ind_access,
    .ind_ptr_sel, .ind_ptr_value, .watchdog_expired_n, .sleep_entered_n,
    .stack_space_flag);

  task automatic results;
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] ad,
                     input logic [31:0] wd, input logic [3:0] be);
    @(posedge mclk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= ad;
    avs_writedata <= wd;
    avs_byteenable <= be;
    // no cycle count assumed; only the watchdog ends a wait that hangs
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    bus(1'h0, ad, 32'h0000_0000, 4'h0);
    chk("readback", rd, e);
  endtask
  function automatic logic [11:0] model(asf_pkg::asf_op_type o,
                                        logic [7:0] a, b, logic [3:0] f);
    logic       sb;
    logic [7:0] x, r;
    logic [8:0] s;
    logic [4:0] n;
    logic [3:0] q;
    sb = o inside {asf_pkg::ASF_OP_SUB, asf_pkg::ASF_OP_DEC};
    x = (o inside {asf_pkg::ASF_OP_INC, asf_pkg::ASF_OP_DEC}) ? 8'h01 : b;
    x = sb ? ~x : x;
    s = {1'b0, a} + {1'b0, x} + {8'h00, sb};
    n = {1'b0, a[3:0]} + {1'b0, x[3:0]} + {4'h0, sb};
    r = a;
    q = f;
    case (o)
      asf_pkg::ASF_OP_ADD, asf_pkg::ASF_OP_SUB,
      asf_pkg::ASF_OP_INC, asf_pkg::ASF_OP_DEC: begin
        r = s[7:0];
        q = {a[7] == x[7] && r[7] != a[7], r == 8'h00, n[4], s[8]};
      end
      asf_pkg::ASF_OP_AND: r = a & b;
      asf_pkg::ASF_OP_IOR: r = a | b;
      asf_pkg::ASF_OP_XOR: r = a ^ b;
      asf_pkg::ASF_OP_CLR: r = 8'h00;
      asf_pkg::ASF_OP_RRC: r = {f[0], a[7:1]};
      asf_pkg::ASF_OP_RLC: r = {a[6:0], f[0]};
      default: ;
    endcase
    if (o inside {asf_pkg::ASF_OP_RRC, asf_pkg::ASF_OP_RLC})
      q[0] = (o == asf_pkg::ASF_OP_RRC) ? a[0] : a[7];
    if (o inside {asf_pkg::ASF_OP_AND, asf_pkg::ASF_OP_IOR,
                  asf_pkg::ASF_OP_XOR, asf_pkg::ASF_OP_CLR})
      q[2] = (r == 8'h00);
    return {r, q};
  endfunction

  initial begin
    {mclk, rst_n, avs_read, avs_write, rd} = '0;
    {avs_address, avs_writedata, avs_byteenable, error_cnt, checked} = '0;
    pr = '{16'h7F01, 16'hFF01, 16'h0001, 16'h8888};
    f_e = 4'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'h1;
    rdc(`ASF_ADDR_ARITH, 32'h0000_00F0);
    rdc(`ASF_ADDR_CPU_STATE, 32'h0000_003C);
    bus(1'h1, `ASF_ADDR_CPU_STATE, 32'h0000_0000, 4'hF);
    rdc(`ASF_ADDR_CPU_STATE, 32'h0000_002C);
    chk("irq disable", global_irq_disable, 32'h0000_0000);
    i_dp.hw(3'h2);
    bus(1'h1, `ASF_ADDR_CPU_STATE, 32'h0000_00FF, 4'hF);
    rdc(`ASF_ADDR_CPU_STATE, 32'h0000_0014);
    bus(1'h1, `ASF_ADDR_CPU_STATE, 32'h0000_0000, 4'h0);
    bus(1'h1, 8'h40, 32'h0000_00FF, 4'hF);
    rdc(8'h40, 32'h0000_0000);
    rdc(`ASF_ADDR_CPU_STATE, 32'h0000_0014);
    for (int i = 0; i < 12; i++) begin
      for (int j = 0; j < 4; j++) begin
        o = asf_pkg::asf_op_type'(i[3:0]);
        m = model(o, pr[j][15:8], pr[j][7:0], f_e);
        i_dp.op(o, pr[j][15:8], pr[j][7:0]);
        chk("alu", {alu_result_valid, alu_result, alu_flags},
            {1'h1, m});
        f_e = m[3:0];
      end
    end
    rdc(`ASF_ADDR_ARITH, {24'h00_0000, 4'hF, f_e});
    // flags cleared first so a stepped pointer reaching zero would show
    for (int s = 0; s < 2; s++) begin
      for (int md = 0; md < 4; md++) begin
        for (int j = 0; j < 2; j++) begin
          bus(1'h1, `ASF_ADDR_ARITH, {24'h0, md[1:0], md[1:0], 4'h0}, 4'h1);
          v = j[7:0];
          pe = md == 0 ? v - 8'h01 : md == 1 ? v + 8'h01 : v;
          i_dp.step(s[0], v);
          chk("pointer", {ptr_update_valid, ptr_update_sel, ptr_update_value,
              pointer_one_mode_sel, pointer_zero_mode_sel},
              {1'h1, s[0], pe, md[1:0], md[1:0]});
          chk("flags", alu_flags, 32'h0000_0000);
        end
      end
    end
    results();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    results();
  end
endmodule
